// ### rtl/tx_descriptor_ring.sv
// Notes on behaviour
// - Back-to-back frames leave the packet buffer only after the adaptive gap.
// - The adaptive gap counts 8 ns steps over its full 16-bit width.
// - The adaptive gap adds to the back-to-back gap time.
// - No adaptive gap after a receive or for non back-to-back frames.
// - Retransmission after a collision ignores the adaptive gap.
// - The adaptive gap acts only above the standard minimum spacing.
// - Base low bits 3:0 ignore writes and read zero.
// - The ring start is base high as 63:32 and base low 31:4.
// - Ring length is a multiple of 128 in bits 19:7, bits 6:0 read zero.
// - The head is a 16-bit index of 16-byte descriptors from the base.
// - Hardware advances the head as descriptors complete.
// - A head write while enabled is taken as is; results are undefined.
// - Descriptors from head up to tail are offered for transmission.
//
// The AXI4-Lite slave port was decided locally.
`timescale 1ns/100ps
`default_nettype none
`include "txring_consts.svh"

module tx_descriptor_ring #(
  parameter int ADDR_W = 16
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  input wire logic dev_soft_reset,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output txring_pkg::axi_resp_t s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output txring_pkg::axi_resp_t s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic transmit_function_enable,
  output logic desc_valid,
  output logic [63:0] desc_addr,
  input wire logic desc_done,
  input wire logic pkt_valid,
  input wire logic pkt_b2b,
  input wire logic pkt_after_rx,
  input wire logic pkt_retry,
  output logic pkt_ready,
  input wire logic tx_done
);
  import txring_pkg::*;

  if (ADDR_W < 16 || ADDR_W > 32) begin : g_bad_addr_w
    $error("ADDR_W must be 16 to 32");
  end

  // ----------------------------------------
  // Decoding
  // ----------------------------------------
  function automatic reg_sel_t decode(input logic [15:0] a);
    logic [15:0] w;
    w = {a[15:2], 2'b00};
    case (w)
      `OFS_ADAPTIVE_GAP: decode = SEL_GAP;
      `OFS_BASE_LOW: decode = SEL_BASE_LO;
      `OFS_BASE_HIGH: decode = SEL_BASE_HI;
      `OFS_RING_LENGTH: decode = SEL_LEN;
      `OFS_HEAD_INDEX: decode = SEL_HEAD;
      `OFS_TAIL_INDEX: decode = SEL_TAIL;
      `OFS_TX_CONTROL: decode = SEL_CTL;
      default: decode = SEL_NONE;
    endcase
  endfunction : decode

  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] nw,
                                        input logic [3:0] strb);
    for (int i = 0; i < 4; i++) begin
      merge[8*i +: 8] = strb[i] ? nw[8*i +: 8] : old[8*i +: 8];
    end
  endfunction : merge

  // ----------------------------------------
  // Register state
  // ----------------------------------------
  logic [`ADAPTIVE_W-1:0] gap_q;
  logic [31:`BASE_LOW_LSB] base_lo_q;
  logic [31:0] base_hi_q;
  logic [`LEN_MSB:`LEN_LSB] len_q;
  logic [`INDEX_W-1:0] head_q, head_d;
  logic [`INDEX_W-1:0] tail_q;
  logic en_q;
  logic [`GAP_TIME_W-1:0] gap_time_q;
  logic [63:0] desc_addr_q;

  // ----------------------------------------
  // Bus slave state
  // ----------------------------------------
  logic aw_have_q, w_have_q, bvalid_q, rvalid_q;
  logic [15:0] awaddr_q;
  logic [31:0] wdata_q, rdata_q;
  logic [3:0] wstrb_q;
  axi_resp_t bresp_q, rresp_q;
  reg_sel_t rsel_q;

  logic [31:0] word [8];
  reg_sel_t wsel, rsel;
  logic wr_fire, rd_fire, aw_fire, w_fire;
  logic [31:0] wval;
  logic pending, sw_srst, clr;
  logic head_wr, head_adv, head_last;
  logic [15:0] ring_count;

  assign s_axi_awready = ce && !aw_have_q;
  assign s_axi_wready = ce && !w_have_q;
  assign s_axi_arready = ce && !rvalid_q;
  assign aw_fire = s_axi_awvalid && s_axi_awready;
  assign w_fire = s_axi_wvalid && s_axi_wready;
  assign rd_fire = s_axi_arvalid && s_axi_arready;
  // Address and data may come in either order; write when both held
  assign wr_fire = ce && aw_have_q && w_have_q && !bvalid_q;

  assign wsel = decode(awaddr_q);
  assign rsel = decode(s_axi_araddr[15:0]);

  assign word[SEL_NONE] = 32'h00000000;
  assign word[SEL_GAP] = {16'h0000, gap_q};
  assign word[SEL_BASE_LO] = {base_lo_q, 4'h0};
  assign word[SEL_BASE_HI] = base_hi_q;
  assign word[SEL_LEN] = {12'h000, len_q, 7'h00};
  assign word[SEL_HEAD] = {16'h0000, head_q};
  assign word[SEL_TAIL] = {16'h0000, tail_q};
  assign word[SEL_CTL] = {6'h00, gap_time_q, 7'h00, pending, 6'h00, 1'b0,
                          en_q};
  assign wval = merge(word[wsel], wdata_q, wstrb_q);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_have_q <= 1'b0;
      w_have_q <= 1'b0;
      awaddr_q <= 16'h0000;
      wdata_q <= 32'h00000000;
      wstrb_q <= 4'h0;
      bvalid_q <= 1'b0;
      bresp_q <= RESP_OKAY;
    end else if (ce) begin
      if (aw_fire) begin
        aw_have_q <= 1'b1;
        awaddr_q <= s_axi_awaddr[15:0];
      end else if (wr_fire) begin
        aw_have_q <= 1'b0;
      end
      if (w_fire) begin
        w_have_q <= 1'b1;
        wdata_q <= s_axi_wdata;
        wstrb_q <= s_axi_wstrb;
      end else if (wr_fire) begin
        w_have_q <= 1'b0;
      end
      if (wr_fire) begin
        bvalid_q <= 1'b1;
        bresp_q <= (wsel == SEL_NONE) ? RESP_SLVERR : RESP_OKAY;
      end else if (s_axi_bready) begin
        bvalid_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_q <= 1'b0;
      rdata_q <= 32'h00000000;
      rresp_q <= RESP_OKAY;
      rsel_q <= SEL_NONE;
    end else if (ce) begin
      if (rd_fire) begin
        rvalid_q <= 1'b1;
        rdata_q <= word[rsel];
        rresp_q <= (rsel == SEL_NONE) ? RESP_SLVERR : RESP_OKAY;
        rsel_q <= rsel;
      end else if (s_axi_rready) begin
        rvalid_q <= 1'b0;
      end
    end
  end

  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rdata = rdata_q;
  assign s_axi_rresp = rresp_q;

  // ----------------------------------------
  // Ring registers
  // ----------------------------------------
  assign sw_srst = wr_fire && (wsel == SEL_CTL) &&
                   wval[`CTL_SOFT_RESET_BIT];
  assign clr = dev_soft_reset || sw_srst;

  // Descriptor count is ring bytes over 16, i.e. length field times 8
  assign ring_count = {len_q, 3'b000};
  assign head_last = head_q == ring_count - 16'h0001;
  assign pending = en_q && (head_q != tail_q);
  // Taken even while enabled; cached descriptors are then stale
  assign head_wr = wr_fire && (wsel == SEL_HEAD);
  assign head_adv = desc_done && pending;
  always_comb begin
    head_d = head_q;
    if (head_wr) begin
      head_d = wval[15:0];
    end else if (head_adv) begin
      head_d = head_last ? 16'h0000 : head_q + 16'h0001;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn || (ce && clr)) begin
      gap_q <= `ADAPTIVE_RESET;
      base_lo_q <= 28'h0000000;
      base_hi_q <= 32'h00000000;
      len_q <= 13'h0000;
      head_q <= 16'h0000;
      tail_q <= 16'h0000;
      en_q <= 1'b0;
      gap_time_q <= `GAP_TIME_RESET;
    end else if (ce) begin
      head_q <= head_d;
      if (wr_fire) begin
        unique case (wsel)
          SEL_GAP: gap_q <= wval[15:0];
          SEL_BASE_LO: base_lo_q <= wval[31:`BASE_LOW_LSB];
          SEL_BASE_HI: base_hi_q <= wval;
          SEL_LEN: len_q <= wval[`LEN_MSB:`LEN_LSB];
          SEL_TAIL: tail_q <= wval[15:0];
          SEL_CTL: begin
            en_q <= wval[`CTL_ENABLE_BIT];
            gap_time_q <= wval[`CTL_GAP_MSB:`CTL_GAP_LSB];
          end
          SEL_HEAD, SEL_NONE: ;
        endcase
      end
    end
  end

  // ----------------------------------------
  // Descriptor address
  // ----------------------------------------
  // Registered so the 64-bit add stays off the fetch path
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      desc_addr_q <= 64'h0000000000000000;
    end else if (ce) begin
      desc_addr_q <= {base_hi_q, base_lo_q, 4'h0} +
                     {44'h00000000000, head_q, 4'h0};
    end
  end

  assign desc_addr = desc_addr_q;
  assign desc_valid = pending;
  assign transmit_function_enable = en_q;

  // ----------------------------------------
  // Inter-frame throttle
  // ----------------------------------------
  gap_throttle u_throttle (
    .aclk(aclk),
    .aresetn(aresetn),
    .ce(ce),
    .clear(clr),
    .enable(en_q),
    .adaptive_gap_value(gap_q),
    .back_to_back_gap_time(gap_time_q),
    .pkt_valid(pkt_valid),
    .pkt_b2b(pkt_b2b),
    .pkt_after_rx(pkt_after_rx),
    .pkt_retry(pkt_retry),
    .pkt_ready(pkt_ready),
    .tx_done(tx_done)
  );

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  property p_base_low_zero;
    s_axi_rvalid && rsel_q == SEL_BASE_LO |-> s_axi_rdata[3:0] == 4'h0;
  endproperty
  a_base_low_zero: assert property (p_base_low_zero)
    else $error("base low bits 3:0 not zero");

  property p_len_zero;
    s_axi_rvalid && rsel_q == SEL_LEN
      |-> s_axi_rdata[6:0] == 7'h00 && s_axi_rdata[31:20] == 12'h000;
  endproperty
  a_len_zero: assert property (p_len_zero)
    else $error("ring length fixed-zero bits not zero");

  property p_ring_addr;
    ce |=> desc_addr == {$past(base_hi_q), $past(base_lo_q), 4'h0} +
                        {44'h00000000000, $past(head_q), 4'h0};
  endproperty
  a_ring_addr: assert property (p_ring_addr)
    else $error("descriptor address does not follow base and head");

  property p_head_step;
    ce && !clr && !head_wr && head_adv && !head_last
      |=> head_q == $past(head_q) + 16'h0001;
  endproperty
  a_head_step: assert property (p_head_step)
    else $error("head did not advance on completed descriptor");

  property p_head_wrap;
    ce && !clr && !head_wr && head_adv && head_last |=> head_q == 16'h0000;
  endproperty
  a_head_wrap: assert property (p_head_wrap)
    else $error("head did not wrap after last descriptor");

  c_wrap: cover property (ce && head_adv && head_last);
  c_write_ok: cover property (s_axi_bvalid && s_axi_bresp == RESP_OKAY);
  c_read_head: cover property (s_axi_rvalid && rsel_q == SEL_HEAD);

endmodule : tx_descriptor_ring

`default_nettype wire

// ### rtl/txring_consts.svh
`ifndef TXRING_CONSTS_SVH
`define TXRING_CONSTS_SVH

// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define OFS_ADAPTIVE_GAP 16'h0458
`define OFS_BASE_LOW 16'h3800
`define OFS_BASE_HIGH 16'h3804
`define OFS_RING_LENGTH 16'h3808
`define OFS_HEAD_INDEX 16'h3810
`define OFS_TAIL_INDEX 16'h3818
`define OFS_TX_CONTROL 16'h3840

// ----------------------------------------
// Field positions and widths
// ----------------------------------------
`define BASE_LOW_LSB 4
`define LEN_LSB 7
`define LEN_MSB 19
`define DESC_BYTES_SHIFT 4
`define CTL_ENABLE_BIT 0
`define CTL_SOFT_RESET_BIT 1
`define CTL_PENDING_BIT 8
`define CTL_GAP_LSB 16
`define CTL_GAP_MSB 25
`define GAP_TIME_W 10
`define ADAPTIVE_W 16
`define INDEX_W 16

// ----------------------------------------
// Reset values
// ----------------------------------------
`define GAP_TIME_RESET 10'h00A
`define ADAPTIVE_RESET 16'h0000

// ----------------------------------------
// Timing
// ----------------------------------------
`define GAP_STEP_NS 8
`define CLK_PERIOD_NS 10
`define MIN_IFS_STEPS 16'h000C

`endif

// ### rtl/txring_pkg.sv
package txring_pkg;

  typedef enum logic [1:0] {
    RESP_OKAY = 2'b00,
    RESP_SLVERR = 2'b10
  } axi_resp_t;

  typedef enum logic {
    GAP_S = 1'b0,
    BUSY_S = 1'b1
  } throttle_state_t;

  typedef enum logic [2:0] {
    SEL_NONE = 3'b000,
    SEL_GAP = 3'b001,
    SEL_BASE_LO = 3'b010,
    SEL_BASE_HI = 3'b011,
    SEL_LEN = 3'b100,
    SEL_HEAD = 3'b101,
    SEL_TAIL = 3'b110,
    SEL_CTL = 3'b111
  } reg_sel_t;

endpackage : txring_pkg

// ### rtl/gap_throttle.sv
`timescale 1ns/100ps
`default_nettype none
`include "txring_consts.svh"

module gap_throttle (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  input wire logic clear,
  input wire logic enable,
  input wire logic [`ADAPTIVE_W-1:0] adaptive_gap_value,
  input wire logic [`GAP_TIME_W-1:0] back_to_back_gap_time,
  input wire logic pkt_valid,
  input wire logic pkt_b2b,
  input wire logic pkt_after_rx,
  input wire logic pkt_retry,
  output logic pkt_ready,
  input wire logic tx_done
);
  import txring_pkg::*;

  localparam logic [19:0] SAT_NS = 20'hFFFFF;
  localparam logic [19:0] TICK_NS = 20'(`CLK_PERIOD_NS);

  throttle_state_t state_q, state_d;
  logic [19:0] elapsed_q, elapsed_d;
  logic [15:0] adaptive_eff;
  logic [16:0] target_steps;
  logic [19:0] target_ns;
  logic gap_met, grant, adaptive_on;

  // ----------------------------------------
  // Gap target
  // ----------------------------------------
  // Values at or below the standard minimum spacing add nothing
  assign adaptive_on = adaptive_gap_value > `MIN_IFS_STEPS;
  // Only true back-to-back frames, not after receive or retry
  assign adaptive_eff = (pkt_b2b && !pkt_after_rx && !pkt_retry &&
                         adaptive_on) ? adaptive_gap_value : 16'h0000;
  assign target_steps = {7'h00, back_to_back_gap_time} +
                        {1'b0, adaptive_eff};
  assign target_ns = 20'(target_steps * `GAP_STEP_NS);
  assign gap_met = elapsed_q >= target_ns;
  assign pkt_ready = ce && enable && (state_q == GAP_S) && gap_met;
  assign grant = pkt_ready && pkt_valid;

  // ----------------------------------------
  // Elapsed time since last frame ended
  // ----------------------------------------
  // Counted in ns so 8 ns steps stay exact on a 10 ns clock
  always_comb begin
    state_d = state_q;
    elapsed_d = elapsed_q;
    unique case (state_q)
      GAP_S: begin
        if (grant) begin
          state_d = BUSY_S;
        end
        if (elapsed_q > SAT_NS - TICK_NS) begin
          elapsed_d = SAT_NS;
        end else begin
          elapsed_d = elapsed_q + TICK_NS;
        end
      end
      BUSY_S: begin
        if (tx_done) begin
          state_d = GAP_S;
          elapsed_d = 20'h00000;
        end
      end
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn || (ce && clear)) begin
      state_q <= GAP_S;
      elapsed_q <= 20'hFFFFF;
    end else if (ce) begin
      state_q <= state_d;
      elapsed_q <= elapsed_d;
    end
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  logic [16:0] cyc_q;
  logic [20:0] cyc_ns;
  always_ff @(posedge aclk) begin
    if (!aresetn || (ce && clear)) begin
      cyc_q <= 17'h1FFFF;
    end else if (ce) begin
      if (state_q == BUSY_S && tx_done) begin
        cyc_q <= 17'h00000;
      end else if (state_q == GAP_S && cyc_q != 17'h1FFFF) begin
        cyc_q <= cyc_q + 17'h00001;
      end
    end
  end
  assign cyc_ns = 21'(cyc_q * `CLK_PERIOD_NS);

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  property p_b2b_delay;
    grant && pkt_b2b && !pkt_after_rx && !pkt_retry && adaptive_on
      |-> cyc_ns >= 21'(adaptive_gap_value * `GAP_STEP_NS);
  endproperty
  a_b2b_delay: assert property (p_b2b_delay)
    else $error("back-to-back frame released before adaptive gap");

  property p_additive;
    grant |-> cyc_ns >= {1'b0, target_ns};
  endproperty
  a_additive: assert property (p_additive)
    else $error("frame released before combined gap");

  property p_step;
    pkt_valid && enable && ce && state_q == GAP_S &&
      cyc_q != 17'h1FFFF && cyc_ns >= {1'b0, target_ns}
      |-> pkt_ready;
  endproperty
  a_step: assert property (p_step)
    else $error("gap held longer than its programmed steps");

  property p_not_b2b;
    pkt_valid && !pkt_b2b && enable && ce && state_q == GAP_S &&
      cyc_ns >= 21'(back_to_back_gap_time * `GAP_STEP_NS)
      |-> pkt_ready;
  endproperty
  a_not_b2b: assert property (p_not_b2b)
    else $error("adaptive gap applied to non back-to-back frame");

  property p_retry;
    pkt_valid && pkt_retry && enable && ce && state_q == GAP_S &&
      cyc_ns >= 21'(back_to_back_gap_time * `GAP_STEP_NS)
      |-> pkt_ready;
  endproperty
  a_retry: assert property (p_retry)
    else $error("adaptive gap applied to retransmission");

  property p_small_value;
    pkt_valid && !adaptive_on && enable && ce && state_q == GAP_S &&
      cyc_ns >= 21'(back_to_back_gap_time * `GAP_STEP_NS)
      |-> pkt_ready;
  endproperty
  a_small_value: assert property (p_small_value)
    else $error("adaptive value below minimum spacing took effect");

  c_adaptive_grant: cover property (grant && adaptive_on && pkt_b2b);

endmodule : gap_throttle

`default_nettype wire

// ### sim/desc_host_model.sv
`timescale 1ns/100ps
`default_nettype none

module desc_host_model (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic desc_valid,
  input wire logic [3:0] slow,
  output logic desc_done,
  output logic [15:0] done_count
);
  logic [3:0] wait_q;

  // Idles slow cycles between descriptors so prompt and lazy hosts both run
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      desc_done <= 1'b0;
      wait_q <= 4'h0;
      done_count <= 16'h0000;
    end else if (desc_done) begin
      desc_done <= 1'b0;
      wait_q <= slow;
      // Completions are counted here; the head is never read for this
      done_count <= done_count + 16'h0001;
    end else if (desc_valid && wait_q == 4'h0) begin
      desc_done <= 1'b1;
    end else if (desc_valid) begin
      wait_q <= wait_q - 4'h1;
    end
  end
endmodule : desc_host_model

`default_nettype wire

// ### sim/tx_descriptor_ring_bench.sv
`timescale 1ns/100ps
`default_nettype none
`include "txring_consts.svh"

module tx_descriptor_ring_bench;
  import txring_pkg::*;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic ce = 1'b1;
  logic dev_soft_reset = 1'b0;
  logic [15:0] awaddr = 16'h0000;
  logic [15:0] araddr = 16'h0000;
  logic [31:0] wdata = 32'h0000_0000;
  logic [3:0] wstrb = 4'hF;
  logic [2:0] prot = 3'h0;
  // Responses are always accepted, so bready and rready stay high
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b1;
  logic arvalid = 1'b0, rready = 1'b1, tx_done = 1'b0;
  logic pkt_valid = 1'b0, pkt_b2b = 1'b0, pkt_after_rx = 1'b0;
  logic pkt_retry = 1'b0;
  logic [3:0] slow = 4'h3;
  logic awready, wready, bvalid, arready, rvalid, enable;
  logic desc_valid, desc_done, pkt_ready;
  logic [31:0] rdata;
  logic [63:0] desc_addr, base;
  logic [15:0] done_count;
  axi_resp_t bresp, rresp;
  int n_fail = 0;
  int compares = 0;
  int gap_cnt = 0;
  int i;
  bit armed = 1'b0;
  logic [33:0] rq[$];
  axi_resp_t bq[$];
  int gq[$];

  always #5 aclk = ~aclk;

  // ----------------------------------------
  // Design and host
  // ----------------------------------------
  tx_descriptor_ring #(.ADDR_W(16)) tx_descriptor_ring_i (
    .aclk(aclk), .aresetn(aresetn), .ce(ce),
    .dev_soft_reset(dev_soft_reset),
    .s_axi_awaddr(awaddr), .s_axi_awprot(prot), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arprot(prot), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .transmit_function_enable(enable),
    .desc_valid(desc_valid), .desc_addr(desc_addr), .desc_done(desc_done),
    .pkt_valid(pkt_valid), .pkt_b2b(pkt_b2b), .pkt_after_rx(pkt_after_rx),
    .pkt_retry(pkt_retry), .pkt_ready(pkt_ready), .tx_done(tx_done));

  desc_host_model desc_host_model_i (.aclk(aclk), .aresetn(aresetn),
    .desc_valid(desc_valid), .slow(slow), .desc_done(desc_done),
    .done_count(done_count));

  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic check(input string what, input logic [63:0] exp,
                       input logic [63:0] got);
    compares++;
    if (exp !== got) begin
      $display("mismatch %s expected %h seen %h", what, exp, got);
      n_fail++;
    end
  endtask : check

  task automatic test_done;
    $display("checks %0d failures %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : test_done

  task automatic stuck(input string what);
    $display("mismatch %s expected answer seen timeout", what);
    n_fail++;
    test_done();
  endtask : stuck

  task automatic wr(input logic [15:0] a, input logic [31:0] d,
                    input axi_resp_t r);
    bit aw_ok = 1'b0;
    bit w_ok = 1'b0;
    int k;
    bq.push_back(r);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    for (k = 0; k < 50 && !(aw_ok && w_ok); k++) begin
      @(posedge aclk);
      if (awvalid && awready) begin
        awvalid <= 1'b0;
        aw_ok = 1'b1;
      end
      if (wvalid && wready) begin
        wvalid <= 1'b0;
        w_ok = 1'b1;
      end
    end
    for (k = 0; k < 50; k++) begin
      @(posedge aclk);
      if (bvalid) break;
    end
    if (k == 50 || !aw_ok || !w_ok) stuck("write");
  endtask : wr

  task automatic rd(input logic [15:0] a, input logic [31:0] d,
                    input axi_resp_t r);
    int k;
    rq.push_back({r, d});
    araddr <= a;
    arvalid <= 1'b1;
    for (k = 0; k < 50; k++) begin
      @(posedge aclk);
      if (arready) break;
    end
    arvalid <= 1'b0;
    for (k = 0; k < 50; k++) begin
      @(posedge aclk);
      if (rvalid) break;
    end
    if (k == 50) stuck("read");
  endtask : rd

  // One packet handed over, then its frame ends three cycles later
  task automatic pkt(input bit b2b, input bit rx, input bit rt,
                     input int exp);
    int k;
    if (exp >= 0) gq.push_back(exp);
    pkt_b2b <= b2b;
    pkt_after_rx <= rx;
    pkt_retry <= rt;
    pkt_valid <= 1'b1;
    for (k = 0; k < 60000; k++) begin
      @(posedge aclk);
      if (pkt_ready) break;
    end
    if (k == 60000) stuck("packet");
    pkt_valid <= 1'b0;
    repeat (3) @(posedge aclk);
    tx_done <= 1'b1;
    @(posedge aclk);
    tx_done <= 1'b0;
  endtask : pkt

  // A priming packet first, so the measured gap starts from a clean frame
  task automatic gcase(input int gt, input int a, input bit b2b,
                       input bit rx, input bit rt);
    int add;
    add = (b2b && !rx && !rt && a > 12) ? a : 0;
    wr(`OFS_TX_CONTROL, 32'((gt << 16) | 1), RESP_OKAY);
    wr(`OFS_ADAPTIVE_GAP, 32'(a), RESP_OKAY);
    pkt(1'b0, 1'b0, 1'b0, -1);
    pkt(b2b, rx, rt, (8 * (gt + add) + 9) / 10);
  endtask : gcase

  // ----------------------------------------
  // Result watcher
  // ----------------------------------------
  always @(posedge aclk) begin
    if (bvalid && bready) check("bresp", bq.pop_front(), bresp);
    if (rvalid && rready) check("rdata", rq.pop_front(), {rresp, rdata});
    if (tx_done) begin
      gap_cnt = 0;
      armed = 1'b1;
    end else if (armed && pkt_valid && pkt_ready) begin
      armed = 1'b0;
      if (gq.size() > 0) check("gap", gq.pop_front(), gap_cnt);
    end else if (armed) begin
      gap_cnt++;
    end
  end

  initial begin
    void'($urandom(28));
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rd(`OFS_TX_CONTROL, 32'h000A_0000, RESP_OKAY);
    rd(`OFS_ADAPTIVE_GAP, 32'h0000_0000, RESP_OKAY);
    rd(`OFS_RING_LENGTH, 32'h0000_0000, RESP_OKAY);
    rd(`OFS_HEAD_INDEX, 32'h0000_0000, RESP_OKAY);
    wr(`OFS_BASE_LOW, 32'hFFFF_FFFF, RESP_OKAY);
    rd(`OFS_BASE_LOW, 32'hFFFF_FFF0, RESP_OKAY);
    wr(`OFS_RING_LENGTH, 32'hFFFF_FFFF, RESP_OKAY);
    rd(`OFS_RING_LENGTH, 32'h000F_FF80, RESP_OKAY);
    wr(`OFS_ADAPTIVE_GAP, 32'hFFFF_FFFF, RESP_OKAY);
    rd(`OFS_ADAPTIVE_GAP, 32'h0000_FFFF, RESP_OKAY);
    wr(`OFS_HEAD_INDEX, 32'hFFFF_FFFF, RESP_OKAY);
    rd(`OFS_HEAD_INDEX, 32'h0000_FFFF, RESP_OKAY);
    wr(16'h0100, 32'h1234_5678, RESP_SLVERR);
    rd(16'h0100, 32'h0000_0000, RESP_SLVERR);
    base = {32'($urandom()), 32'h0000_1000};
    wr(`OFS_BASE_HIGH, base[63:32], RESP_OKAY);
    wr(`OFS_BASE_LOW, 32'h0000_100C, RESP_OKAY);
    wr(`OFS_RING_LENGTH, 32'h0000_0080, RESP_OKAY);
    wr(`OFS_HEAD_INDEX, 32'h0000_0006, RESP_OKAY);
    wr(`OFS_TAIL_INDEX, 32'h0000_0002, RESP_OKAY);
    check("desc_addr", base + 64'h60, desc_addr);
    wr(`OFS_TX_CONTROL, 32'h000A_0001, RESP_OKAY);
    check("enable", 64'd1, enable);
    check("desc_valid", 64'd1, desc_valid);
    for (i = 0; i < 300 && (done_count != 4 || desc_valid); i++) begin
      @(posedge aclk);
    end
    if (i == 300) stuck("ring");
    check("done_count", 64'd4, done_count);
    rd(`OFS_HEAD_INDEX, 32'h0000_0002, RESP_OKAY);
    check("desc_addr", base + 64'h20, desc_addr);
    slow <= 4'h0;
    wr(`OFS_TAIL_INDEX, 32'h0000_0005, RESP_OKAY);
    for (i = 0; i < 300 && (done_count != 7 || desc_valid); i++) begin
      @(posedge aclk);
    end
    if (i == 300) stuck("ring");
    check("done_count", 64'd7, done_count);
    rd(`OFS_HEAD_INDEX, 32'h0000_0005, RESP_OKAY);
    gcase(10, 0, 1'b1, 1'b0, 1'b0);
    gcase(10, 12, 1'b1, 1'b0, 1'b0);
    gcase(10, 13, 1'b1, 1'b0, 1'b0);
    gcase(20, 13, 1'b1, 1'b0, 1'b0);
    gcase(10, 13, 1'b1, 1'b1, 1'b0);
    gcase(10, 13, 1'b0, 1'b0, 1'b0);
    gcase(10, 13, 1'b1, 1'b0, 1'b1);
    gcase(10, 13 + int'($urandom() % 100), 1'b1, 1'b0, 1'b0);
    gcase(10, 65535, 1'b1, 1'b0, 1'b0);
    wr(`OFS_BASE_LOW, 32'h0000_2000, RESP_OKAY);
    wr(`OFS_TX_CONTROL, 32'h000A_0002, RESP_OKAY);
    check("enable", 64'd0, enable);
    rd(`OFS_BASE_LOW, 32'h0000_0000, RESP_OKAY);
    rd(`OFS_ADAPTIVE_GAP, 32'h0000_0000, RESP_OKAY);
    wr(`OFS_RING_LENGTH, 32'h0000_0100, RESP_OKAY);
    dev_soft_reset <= 1'b1;
    @(posedge aclk);
    dev_soft_reset <= 1'b0;
    @(posedge aclk);
    rd(`OFS_RING_LENGTH, 32'h0000_0000, RESP_OKAY);
    test_done();
  end
endmodule : tx_descriptor_ring_bench

`default_nettype wire
